/* File: core/frac_pkg.sv */
// Package with opcodes, register layouts, timing constants and shared types.
package frac_pkg;
  localparam logic [7:0] READ_STATUS_ONE_OP = 8'h05;
  localparam logic [7:0] READ_STATUS_TWO_OP = 8'h07;
  localparam logic [7:0] READ_CONFIG_OP = 8'h35;
  localparam logic [7:0] WRITE_REGISTERS_OP = 8'h01;
  localparam logic [7:0] WRITE_ENABLE_OP = 8'h06;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
  // Status one fields.
  localparam int WIP_POS = 0;
  localparam int WEL_POS = 1;
  localparam int BP_LO = 2;
  localparam int BP_HI = 4;
  localparam int ERASE_ERR_POS = 5;
  localparam int PROG_ERR_POS = 6;
  localparam int STATUS_WRITE_DISABLE_BIT_POS = 7;
  // Configuration one fields.
  localparam int QUAD_EN_POS = 1;
  localparam int BP_TARGET_POS = 3;
  // Bits counted per byte and per nibble.
  localparam logic [4:0] BITS_ONE_BYTE = 5'h08;
  localparam logic [4:0] BITS_TWO_BYTES = 5'h10;
  localparam logic [4:0] BITS_PER_SINGLE = 5'h01;
  localparam logic [4:0] BITS_PER_QUAD = 5'h04;
  // Self-timed write duration.
  localparam int CLK_MHZ = 100;
  localparam int WRITE_TIME_US = 20;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam logic [15:0] WRITE_CYCLES_W = 16'(WRITE_CYCLES);

  typedef enum logic [1:0] {
    FRAC_CMD_NONE,
    FRAC_CMD_READ,
    FRAC_CMD_WRITE,
    FRAC_CMD_IGNORE
  } frac_cmd_t;

  // One serial-clock edge event from the edge detector.
  typedef struct packed {
    logic rise;
    logic fall;
    logic [3:0] data;
    logic sel_n;
  } frac_link_t;

  // A write job handed to the write engine.
  typedef struct packed {
    logic start;
    logic two_bytes;
    logic [7:0] status_byte;
    logic [7:0] config_byte;
  } frac_job_t;
endpackage : frac_pkg

/* File: core/frac_link_sync.sv */
// Synchroniser and edge finder for the serial link pins.
`timescale 1ns/1ps
`default_nettype none
module frac_link_sync
  import frac_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_sync_n,
  // Pins.
  input wire logic sel_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] data_pin,
  // Synchronised events.
  output frac_link_t link
);
  logic [1:0] sel_sync_r;
  logic [1:0] clk_sync_r;
  logic [3:0] dat_s1_r;
  logic [3:0] dat_s2_r;
  logic clk_prev_r;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_sync_r <= 2'h3;
      clk_sync_r <= 2'h0;
      dat_s1_r <= 4'h0;
      dat_s2_r <= 4'h0;
      clk_prev_r <= 1'b0;
    end else begin
      sel_sync_r <= {sel_sync_r[0], sel_n_pin};
      clk_sync_r <= {clk_sync_r[0], sclk_pin};
      dat_s1_r <= data_pin;
      dat_s2_r <= dat_s1_r;
      clk_prev_r <= clk_sync_r[1];
    end
  end

  // Data passes the same two stages as the clock, so it is sampled at the edge it belongs to.
  always_comb begin
    link.rise = clk_sync_r[1] & ~clk_prev_r;
    link.fall = ~clk_sync_r[1] & clk_prev_r;
    link.data = dat_s2_r;
    link.sel_n = sel_sync_r[1];
  end
endmodule : frac_link_sync
`default_nettype wire

/* File: core/frac_write_engine.sv */
// Self-timed register write engine; erase and program run as one timed phase.
`timescale 1ns/1ps
`default_nettype none
module frac_write_engine
  import frac_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_sync_n,
  // Job in.
  input wire frac_job_t job,
  // Array fault inputs.
  input wire logic erase_fail,
  input wire logic program_fail,
  // Results.
  output logic busy,
  output logic done,
  output logic erase_err,
  output logic prog_err
);
  logic [15:0] count_r;
  logic busy_r;
  logic done_r;
  logic erase_err_r;
  logic prog_err_r;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (job.start && !busy_r) begin
        busy_r <= 1'b1;
        count_r <= WRITE_CYCLES_W;
      end else if (busy_r) begin
        if (count_r == 16'h0001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        count_r <= count_r - 16'h0001;
      end
    end
  end

  // Erase and program are one operation; either failure is latched in any busy cycle until the next job.
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      erase_err_r <= 1'b0;
      prog_err_r <= 1'b0;
    end else if (job.start && !busy_r) begin
      erase_err_r <= 1'b0;
      prog_err_r <= 1'b0;
    end else if (busy_r) begin
      erase_err_r <= erase_err_r | erase_fail;
      prog_err_r <= prog_err_r | program_fail;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign erase_err = erase_err_r;
  assign prog_err = prog_err_r;
endmodule : frac_write_engine
`default_nettype wire

/* File: core/frac_top.sv */
// Register access command decoder for the serial flash interface.
// How it works
// [R1] Opcode 05h shifts volatile status one out, even while busy.
// [R2] Continued reads repeat the register, refreshed at each byte start.
// [R3] Quad mode reads status one on four lines, two clocks per byte.
// [R4] Opcode 07h shifts status two out at any time outside quad mode.
// [R5] Host reads status two and config one by other command in quad mode.
// [R6] Opcode 35h shifts volatile config one out, repeating every byte.
// [R7] Write-registers opcode 01h needs the write-enable latch set first.
// [R8] Chip select must rise after exactly 8 or 16 data bits, else discarded.
// [R9] Eight bits update status one; sixteen also update config one.
// [R10] The write erases then programs; failure sets error flags.
// [R11] Host writes zero to reserved register bits.
// [R12] Write starts at chip select rise; busy flag reads one throughout.
// [R13] Completion of the write clears the write-enable latch.
// [R14] Quad mode takes write opcode and data on four lines.
// [R15] Protect-target bit steers block-protect bits to nonvolatile or volatile.
// [R16] Block-protect bits size the read-only area against program and erase.
// [R17] Protect-disable bit zero: writes accepted with latch set.
// [R18] Protect-disable one with protect pin high: writes accepted with latch.
// [R19] Protect-disable one with pin low: writes silently rejected.
// [R20] Hardware protection holds until the protect pin goes high.
// [R21] Quad-enable bit disables hardware protection; pin becomes data line two.
// [R22] Status register starts at 00h.
// [R23] Opcode 06h sets the write-enable latch.
// [R24] Rejected or discarded writes change nothing.
// [R25] A write while busy is ignored; status reads still answer.
`timescale 1ns/1ps
`default_nettype none
module frac_top
  import frac_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial link pins.
  input wire logic sel_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic [3:0] data_oe,
  // Mode.
  input wire logic quad_peripheral_mode,
  // Array fault inputs and protection query.
  input wire logic erase_fail,
  input wire logic program_fail,
  input wire logic [2:0] region_size,
  output logic region_protected,
  // Register view.
  output logic [7:0] status_one_volatile,
  output logic [7:0] status_one_nonvolatile,
  output logic [7:0] config_one_volatile,
  input wire logic [7:0] config_one_nonvolatile,
  input wire logic [7:0] status_two,
  output logic write_enable_latch,
  output logic write_in_progress_flag
);
  logic [1:0] rst_pipe_r;
  logic rst_sync_n;
  frac_link_t link;
  frac_job_t job;
  logic eng_busy;
  logic eng_done;
  logic eng_erase_err;
  logic eng_prog_err;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_r[1];

  frac_link_sync u_sync (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .sel_n_pin(sel_n_pin),
    .sclk_pin(sclk_pin),
    .data_pin(data_in),
    .link(link)
  );

  frac_write_engine u_eng (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .job(job),
    .erase_fail(erase_fail),
    .program_fail(program_fail),
    .busy(eng_busy),
    .done(eng_done),
    .erase_err(eng_erase_err),
    .prog_err(eng_prog_err)
  );

  // Frame tracking.
  logic sel_prev_r;
  logic frame_start;
  logic frame_end;
  logic quad_mode_r;
  logic [4:0] step;
  logic [4:0] op_count_r;
  logic [7:0] op_shift_r;
  logic [7:0] op_nxt;
  logic [4:0] data_count_r;
  logic [15:0] data_shift_r;
  frac_cmd_t cmd_r;
  logic [7:0] read_src_r;
  logic [7:0] out_shift_r;
  logic [3:0] out_bits_r;
  logic out_phase_r;
  logic [2:0] out_bit_idx_r;
  logic [7:0] status_one_volatile_r;
  logic [7:0] status_one_nonvolatile_r;
  logic [7:0] config_one_volatile_r;
  logic wel_r;
  logic hw_protect;
  logic write_allowed;
  logic [7:0] pending_sr_r;
  logic [7:0] pending_cr_r;
  logic pending_two_r;

  assign frame_start = sel_prev_r & ~link.sel_n;
  assign frame_end = ~sel_prev_r & link.sel_n;
  assign step = quad_mode_r ? BITS_PER_QUAD : BITS_PER_SINGLE;
  assign op_nxt = quad_mode_r ? {op_shift_r[3:0], link.data} : {op_shift_r[6:0], link.data[0]};

  // Mode is taken at the start of each frame so it never changes mid-command.
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_prev_r <= 1'b1;
      quad_mode_r <= 1'b0;
    end else begin
      sel_prev_r <= link.sel_n;
      if (frame_start) begin
        quad_mode_r <= quad_peripheral_mode;
      end
    end
  end

  // Opcode and data capture on rising serial clock edges.
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op_count_r <= 5'h00;
      op_shift_r <= 8'h00;
      data_count_r <= 5'h00;
      data_shift_r <= 16'h0000;
      cmd_r <= FRAC_CMD_NONE;
    end else if (frame_start) begin
      op_count_r <= 5'h00;
      data_count_r <= 5'h00;
      cmd_r <= FRAC_CMD_NONE;
    end else if (!link.sel_n && link.rise) begin
      if (op_count_r < BITS_ONE_BYTE) begin
        op_shift_r <= op_nxt;
        op_count_r <= op_count_r + step;
        if (op_count_r + step == BITS_ONE_BYTE) begin
          if (op_nxt == READ_STATUS_ONE_OP) begin
            cmd_r <= FRAC_CMD_READ; // R1 R3
          end else if ((op_nxt == READ_STATUS_TWO_OP || op_nxt == READ_CONFIG_OP)
                       && !quad_mode_r) begin
            cmd_r <= FRAC_CMD_READ; // R4 R5 R6
          end else if (op_nxt == WRITE_REGISTERS_OP) begin
            cmd_r <= FRAC_CMD_WRITE; // R14
          end else begin
            cmd_r <= FRAC_CMD_IGNORE;
          end
        end
      end else begin
        if (cmd_r == FRAC_CMD_WRITE) begin
          if (quad_mode_r) begin
            data_shift_r <= {data_shift_r[11:0], link.data}; // R14
          end else begin
            data_shift_r <= {data_shift_r[14:0], link.data[0]};
          end
        end
        // Every command counts its trailing bits, so a write-enable frame must end on its opcode.
        if (data_count_r <= BITS_TWO_BYTES) begin
          data_count_r <= data_count_r + step;
        end
      end
    end
  end

  // Read source: chosen by opcode, sampled anew at each byte boundary.
  always_comb begin
    if (op_shift_r == READ_STATUS_TWO_OP) begin
      read_src_r = status_two; // R4
    end else if (op_shift_r == READ_CONFIG_OP) begin
      read_src_r = config_one_volatile_r; // R6
    end else begin
      read_src_r = status_one_volatile; // R1
    end
  end

  // Output shifter changes on falling serial clock edges.
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_shift_r <= 8'h00;
      out_bits_r <= 4'h0;
      out_phase_r <= 1'b0;
      out_bit_idx_r <= 3'h0;
    end else if (frame_start || link.sel_n) begin
      out_phase_r <= 1'b0;
      out_bit_idx_r <= 3'h0;
      out_bits_r <= 4'h0;
    end else if (cmd_r == FRAC_CMD_READ && link.fall) begin
      if (quad_mode_r) begin
        if (!out_phase_r) begin
          out_shift_r <= read_src_r; // R2 R3
          out_bits_r <= read_src_r[7:4];
        end else begin
          out_bits_r <= out_shift_r[3:0];
        end
        out_phase_r <= ~out_phase_r;
      end else begin
        if (out_bit_idx_r == 3'h0) begin
          out_shift_r <= {read_src_r[6:0], 1'b0}; // R2
          out_bits_r <= {2'h0, read_src_r[7], 1'b0};
        end else begin
          out_shift_r <= {out_shift_r[6:0], 1'b0};
          out_bits_r <= {2'h0, out_shift_r[7], 1'b0};
        end
        out_bit_idx_r <= out_bit_idx_r + 3'h1;
      end
    end
  end

  always_comb begin
    data_out = out_bits_r;
    if (cmd_r == FRAC_CMD_READ && !link.sel_n) begin
      data_oe = quad_mode_r ? 4'hf : 4'h2;
    end else begin
      data_oe = 4'h0;
    end
  end

  // Protection: STATUS_WRITE_DISABLE_BIT with a low protect pin, unless quad enable repurposes the pin.
  // The protect pin is read through the link synchroniser, never straight from the pin.
  assign hw_protect = status_one_volatile_r[STATUS_WRITE_DISABLE_BIT_POS] & ~link.data[2] & ~config_one_volatile_r[QUAD_EN_POS]; // R19 R20 R21
  assign write_allowed = wel_r & ~hw_protect & ~eng_busy; // R7 R17 R18 R25

  // Job launch at chip select rise after exactly 8 or 16 data bits.
  always_comb begin
    job.start = 1'b0;
    job.two_bytes = (data_count_r == BITS_TWO_BYTES);
    job.status_byte = job.two_bytes ? data_shift_r[15:8] : data_shift_r[7:0];
    job.config_byte = data_shift_r[7:0];
    if (frame_end && cmd_r == FRAC_CMD_WRITE && write_allowed &&
        (data_count_r == BITS_ONE_BYTE || data_count_r == BITS_TWO_BYTES)) begin
      job.start = 1'b1; // R8 R12 R24
    end
  end

  // Latched job values are applied when the self-timed operation ends.
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pending_sr_r <= STATUS_RESET;
      pending_cr_r <= CONFIG_RESET;
      pending_two_r <= 1'b0;
    end else if (job.start) begin
      pending_sr_r <= job.status_byte;
      pending_cr_r <= job.config_byte;
      pending_two_r <= job.two_bytes; // R9
    end
  end

  // Write-enable latch: the opcode alone in a frame sets it.
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wel_r <= 1'b0;
    end else if (eng_done) begin
      wel_r <= 1'b0; // R13
    end else if (frame_end && op_shift_r == WRITE_ENABLE_OP && op_count_r == BITS_ONE_BYTE
                 && data_count_r == 5'h00) begin
      wel_r <= 1'b1; // R23
    end
  end

  // Status and configuration registers.
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_one_volatile_r <= STATUS_RESET; // R22
      status_one_nonvolatile_r <= STATUS_RESET;
      config_one_volatile_r <= CONFIG_RESET;
    end else if (eng_done) begin
      status_one_volatile_r[STATUS_WRITE_DISABLE_BIT_POS] <= pending_sr_r[STATUS_WRITE_DISABLE_BIT_POS];
      status_one_nonvolatile_r[STATUS_WRITE_DISABLE_BIT_POS] <= pending_sr_r[STATUS_WRITE_DISABLE_BIT_POS];
      if (config_one_nonvolatile[BP_TARGET_POS]) begin
        status_one_volatile_r[BP_HI:BP_LO] <= pending_sr_r[BP_HI:BP_LO]; // R15
      end else begin
        status_one_nonvolatile_r[BP_HI:BP_LO] <= pending_sr_r[BP_HI:BP_LO]; // R15
        status_one_volatile_r[BP_HI:BP_LO] <= pending_sr_r[BP_HI:BP_LO];
      end
      status_one_volatile_r[ERASE_ERR_POS] <= eng_erase_err; // R10
      status_one_volatile_r[PROG_ERR_POS] <= eng_prog_err; // R10
      if (pending_two_r) begin
        config_one_volatile_r <= pending_cr_r; // R9
      end
    end
  end

  // Read-only region when the block-protect field covers the requested size.
  assign region_protected = (status_one_volatile_r[BP_HI:BP_LO] != 3'h0) &&
                            (region_size <= status_one_volatile_r[BP_HI:BP_LO]); // R16

  assign write_in_progress_flag = eng_busy; // R12
  assign write_enable_latch = wel_r;
  always_comb begin
    status_one_volatile = status_one_volatile_r;
    status_one_volatile[WIP_POS] = eng_busy;
    status_one_volatile[WEL_POS] = wel_r;
  end
  assign status_one_nonvolatile = status_one_nonvolatile_r;
  assign config_one_volatile = config_one_volatile_r;
endmodule : frac_top
`default_nettype wire

/* File: test/frac_top_checker.sv */
// Port-level assertion checker for the register access command decoder.
`timescale 1ns/1ps
`default_nettype none
module frac_top_checker
  import frac_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial link pins.
  input wire logic sel_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] data_in,
  input wire logic [3:0] data_out,
  input wire logic [3:0] data_oe,
  // Mode.
  input wire logic quad_peripheral_mode,
  // Array faults and protection query.
  input wire logic erase_fail,
  input wire logic program_fail,
  input wire logic [2:0] region_size,
  input wire logic region_protected,
  // Register view.
  input wire logic [7:0] status_one_volatile,
  input wire logic [7:0] status_one_nonvolatile,
  input wire logic [7:0] config_one_volatile,
  input wire logic [7:0] config_one_nonvolatile,
  input wire logic [7:0] status_two,
  input wire logic write_enable_latch,
  input wire logic write_in_progress_flag
);
  logic [15:0] busy_cnt_r;
  // A counter bounds the long write instead of a huge repetition.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 16'h0000;
    end else if (write_in_progress_flag) begin
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    end else begin
      busy_cnt_r <= 16'h0000;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence write_starts;
    $rose(write_in_progress_flag);
  endsequence
  sequence write_ends;
    $fell(write_in_progress_flag);
  endsequence
  reset_clear_a: assert property ($rose(rst_n) |-> status_one_volatile == 8'h00)
    else $error("status one not clear after reset");
  busy_bit_a: assert property (status_one_volatile[WIP_POS] == write_in_progress_flag)
    else $error("busy bit differs from busy flag");
  latch_bit_a: assert property (status_one_volatile[WEL_POS] == write_enable_latch)
    else $error("latch bit differs from latch output");
  latch_frame_a: assert property ($rose(write_enable_latch) |->
    sel_n_pin && $past(sel_n_pin, 2)) else $error("latch set inside a frame");
  write_long_a: assert property (write_in_progress_flag |-> busy_cnt_r <= 16'h07da)
    else $error("register write runs too long");
  write_short_a: assert property (write_ends |-> busy_cnt_r >= 16'h07c6)
    else $error("register write ends too early");
  latch_clear_a: assert property (write_ends |-> ##[0:2] !write_enable_latch)
    else $error("latch not cleared after write");
  start_latch_a: assert property (write_starts |-> write_enable_latch)
    else $error("write started without latch");
  hw_protect_a: assert property (write_starts |-> !(status_one_volatile[STATUS_WRITE_DISABLE_BIT_POS]
    && !data_in[2] && !config_one_volatile[QUAD_EN_POS])) else $error("protected write ran");
  cfg_hold_a: assert property ($changed(config_one_volatile) |->
    $past(write_in_progress_flag, 1) || $past(write_in_progress_flag, 2))
    else $error("config changed outside a write");
  oe_shape_a: assert property (data_oe != 4'h0 |->
    data_oe == (quad_peripheral_mode ? 4'hf : 4'h2)) else $error("bad output enable");
  oe_idle_a: assert property (sel_n_pin [*5] |-> data_oe == 4'h0)
    else $error("output driven while deselected");
  region_a: assert property ($stable(status_one_volatile) && $stable(region_size) |->
    region_protected == (status_one_volatile[4:2] != 3'h0 &&
    region_size <= status_one_volatile[4:2])) else $error("region protection wrong");
endmodule : frac_top_checker
bind frac_top frac_top_checker u_checker (.core_clk, .rst_n, .sel_n_pin, .sclk_pin,
  .data_in, .data_out, .data_oe, .quad_peripheral_mode, .erase_fail, .program_fail,
  .region_size, .region_protected, .status_one_volatile, .status_one_nonvolatile,
  .config_one_volatile, .config_one_nonvolatile, .status_two, .write_enable_latch,
  .write_in_progress_flag);
`default_nettype wire

/* File: test/frac_host_model.sv */
// Serial host controller model driving chip select, serial clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module frac_host_model
  import frac_pkg::*;
(
  // Link pins.
  output logic sel_n,
  output logic sclk,
  output logic [3:0] dq,
  input wire logic [3:0] dq_in,
  // Control.
  input wire logic wp_n,
  input wire logic quad
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    dq = 4'hf;
  end
  // The clock stands low between frames; released lines idle high as if pulled up.
  // Edges sit off the core clock grid for a transfer started on a core clock edge; back-to-back transfers can race the core edge.
  task automatic xfer(input logic [7:0] op, input logic [15:0] wd, input int nw,
                      input int nr, output logic [15:0] rd);
    logic [23:0] sh;
    int step;
    sh = {op, wd};
    rd = 16'h0000;
    step = quad ? 4 : 1;
    #1;
    sel_n = 1'b0;
    for (int i = 0; i < 8 + nw + nr; i += step) begin
      if (i < 8 + nw) begin
        dq = quad ? sh[23 - i -: 4] : {1'b1, wp_n, 1'b1, sh[23 - i]};
      end else begin
        dq = quad ? 4'hf : {1'b1, wp_n, 2'b11};
      end
      #63;
      sclk = 1'b1;
      if (i >= 8 + nw) begin
        rd = quad ? {rd[11:0], dq_in} : {rd[14:0], dq_in[1]};
      end
      #62;
      sclk = 1'b0;
    end
    #63;
    sel_n = 1'b1;
    dq = {1'b1, wp_n, 2'b11};
    #300;
  endtask : xfer
endmodule : frac_host_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking testbench for the register access command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import frac_pkg::*;
  logic core_clk, rst_n, sel_n_pin, sclk_pin, quad_peripheral_mode, erase_fail, program_fail;
  logic wp_n, region_protected, write_enable_latch, write_in_progress_flag;
  logic [3:0] data_in, data_out, data_oe, host_dq;
  logic [2:0] region_size;
  logic [7:0] status_one_volatile, status_one_nonvolatile, config_one_volatile;
  logic [7:0] config_one_nonvolatile, status_two;
  logic [15:0] rd;
  int err_count, total_checks;
  // Wire level of the shared data lines: the device's value where its enable is set, else the host's.
  assign data_in = (data_oe & data_out) | (~data_oe & host_dq);
  frac_top u_dut (.core_clk, .rst_n, .sel_n_pin, .sclk_pin, .data_in, .data_out, .data_oe,
    .quad_peripheral_mode, .erase_fail, .program_fail, .region_size, .region_protected,
    .status_one_volatile, .status_one_nonvolatile, .config_one_volatile,
    .config_one_nonvolatile, .status_two, .write_enable_latch, .write_in_progress_flag);
  frac_host_model u_host (.sel_n(sel_n_pin), .sclk(sclk_pin), .dq(host_dq),
    .dq_in(data_in), .wp_n(wp_n), .quad(quad_peripheral_mode));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic rd_reg(input logic [7:0] op, input int n, input logic [15:0] exp);
    u_host.xfer(op, 16'h0000, 0, n, rd);
    check("read data", exp, rd);
  endtask : rd_reg
  task automatic write_enable_cmd();
    u_host.xfer(WRITE_ENABLE_OP, 16'h0000, 0, 0, rd);
    check("latch set", 16'h0001, {15'h0000, write_enable_latch});
  endtask : write_enable_cmd
  task automatic write_registers_cmd(input logic [15:0] d, input int n);
    u_host.xfer(WRITE_REGISTERS_OP, d, n, 0, rd);
  endtask : write_registers_cmd
  // Waits for the self-timed write, bounded well past its nominal length.
  task automatic wait_idle();
    for (int i = 0; i < 3000 && write_in_progress_flag !== 1'b0; i++) @(negedge core_clk);
    // Registers and the latch settle one cycle after the busy flag drops.
    repeat (2) @(negedge core_clk);
    check("busy flag", 16'h0000, {15'h0000, write_in_progress_flag});
  endtask : wait_idle
  task automatic wr_full(input logic [15:0] d, input int n);
    write_enable_cmd();
    write_registers_cmd(d, n);
    wait_idle();
  endtask : wr_full
  initial begin
    // About 200 us of traffic and writes are expected; three times that is the limit.
    #600000;
    err_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    quad_peripheral_mode = 1'b0;
    erase_fail = 1'b0;
    program_fail = 1'b0;
    wp_n = 1'b0;
    region_size = 3'h2;
    config_one_nonvolatile = 8'h00;
    status_two = 8'ha5;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("status one", 16'h0000, {8'h00, status_one_volatile});
    rd_reg(READ_STATUS_ONE_OP, 8, 16'h0000);
    rd_reg(READ_STATUS_TWO_OP, 16, 16'ha5a5);
    rd_reg(READ_CONFIG_OP, 16, 16'h0000);
    write_registers_cmd(16'h1c00, 8);
    check("refused write", 16'h0000, {8'h00, status_one_volatile});
    write_enable_cmd();
    write_registers_cmd(16'h0c00, 8);
    rd_reg(READ_STATUS_ONE_OP, 16, 16'h0303);
    write_registers_cmd(16'h1c00, 8);
    wait_idle();
    check("status eight", 16'h000c, {8'h00, status_one_volatile});
    check("nonvolatile bp", 16'h000c, {8'h00, status_one_nonvolatile & 8'h1c});
    check("region in", 16'h0001, {15'h0000, region_protected});
    region_size = 3'h4;
    repeat (4) @(negedge core_clk);
    check("region out", 16'h0000, {15'h0000, region_protected});
    write_enable_cmd();
    write_registers_cmd(16'h0000, 12);
    check("discarded", 16'h000e, {8'h00, status_one_volatile});
    write_registers_cmd(16'h8c04, 16);
    wait_idle();
    check("status sixteen", 16'h008c, {8'h00, status_one_volatile});
    check("config sixteen", 16'h0004, {8'h00, config_one_volatile});
    write_enable_cmd();
    write_registers_cmd(16'h0000, 8);
    check("protected", 16'h008e, {8'h00, status_one_volatile});
    wp_n = 1'b1;
    write_registers_cmd(16'h0000, 8);
    wait_idle();
    check("released", 16'h0000, {8'h00, status_one_volatile});
    for (int k = 0; k < 2; k++) begin
      {erase_fail, program_fail} = (k == 0) ? 2'b10 : 2'b01;
      wr_full(16'h0000, 8);
      check("error flag", 16'h0001 << ((k == 0) ? ERASE_ERR_POS : PROG_ERR_POS),
        {8'h00, status_one_volatile & 8'h60});
    end
    {erase_fail, program_fail} = 2'b00;
    quad_peripheral_mode = 1'b1;
    wr_full(16'h1004, 16);
    rd_reg(READ_STATUS_ONE_OP, 16, 16'h1010);
    rd_reg(READ_STATUS_TWO_OP, 8, 16'h00ff);
    wr_full(16'h8c02, 16);
    quad_peripheral_mode = 1'b0;
    wp_n = 1'b0;
    config_one_nonvolatile = 8'h08;
    wr_full(16'h0000, 8);
    check("quad enable", 16'h0000, {8'h00, status_one_volatile});
    check("nonvolatile kept", 16'h000c, {8'h00, status_one_nonvolatile & 8'h1c});
    wrap_up();
  end
endmodule : tb
`default_nettype wire
